/* File: hdl/dsi_i2c_target.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsi_map.svh"
module dsi_i2c_target (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic supply_low_lockout_in,
   input wire logic [1:0] addr_sel_in,
   input wire logic [1:0] tone_gate_input_in,
   input wire logic [1:0] min_current_flag_in,
   input wire logic [1:0] voltage_fault_flag_in,
   input wire logic [1:0] tone_fault_flag_in,
   input wire logic [1:0] over_temp_flag_in,
   input wire logic [1:0] overload_flag_in,
   output logic [1:0] power_on_out,
   output logic [1:0] tone_drv_out,
   output logic [1:0] tone_run_out,
   output logic [1:0][2:0] level_out,
   output logic [1:0] static_limit_out,
   output logic [1:0] thresh_high_out
);
   // ---------------- System clock side ----------------
   // Raw pins gathered for one synchroniser
   logic [16:0] pin_raw;
   // Synchronised pins
   logic [16:0] pin_s;
   // Unpacked synchronised pins
   logic scl_s;
   logic sda_s;
   logic lock_s;
   logic [1:0] asel_s;
   logic [1:0] gate_s;
   logic [9:0] flag_s;
   // Delayed copies for edge detection
   logic scl_d_reg;
   logic sda_d_reg;
   // Bus conditions seen on the system clock
   logic start_det;
   logic stop_det;
   // High between a start and the following stop
   logic frame_open_reg;
   // Link side reset, held while no frame is open
   logic frame_rst_n;
   // Values frozen for the link side during a frame
   logic [1:0][7:0] snap_reg;
   logic lock_snap_reg;
   logic [1:0] asel_snap_reg;
   // Section read and control bytes
   logic [1:0][7:0] rd_w;
   logic [1:0][7:0] ctrl_w;
   // Write event crossing
   logic wt_s;
   logic wt_d_reg;
   logic wr_pulse;
   // ---------------- Link clock side ----------------
   // Engine state and bit counter
   dsi_pkg::dsi_state_t state_reg;
   dsi_pkg::dsi_state_t state_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] cnt_next;
   // Received bits and outgoing byte
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   // Pull-down wanted after the next falling clock edge
   logic drv_pend_reg;
   logic drv_next;
   // Pull-down applied on the data line
   logic sda_oe_reg;
   // Section chosen by the address byte
   logic sec_sel_reg;
   // Write capture, kept across frames for the toggle crossing
   logic [7:0] wr_data_reg;
   logic wr_sec_reg;
   logic wr_tog_reg;
   logic wr_fire;
   // Byte decoding on the link side
   logic [7:0] byte_w;
   logic last_bit;
   logic ack_slot;
   logic addr_hit;

   // Pins from outside pass two flops first on the system side; the link engine uses scl_in and sda_in directly
   assign pin_raw = {scl_in, sda_in, supply_low_lockout_in, addr_sel_in, tone_gate_input_in,
      min_current_flag_in, voltage_fault_flag_in, tone_fault_flag_in, over_temp_flag_in, overload_flag_in};

   dsi_sync #(.W(17)) u_pin_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .d_in(pin_raw),
      .q_out(pin_s)
   );

   assign scl_s = pin_s[16];
   assign sda_s = pin_s[15];
   assign lock_s = pin_s[14];
   assign asel_s = pin_s[13:12];
   assign gate_s = pin_s[11:10];
   assign flag_s = pin_s[9:0];

   // Edge detection of the two bus lines
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         scl_d_reg <= 1'b0;
         sda_d_reg <= 1'b0;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // Data edges while the clock stays high mark start and stop
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // Frame window; a start without stop is simply kept open
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         frame_open_reg <= 1'b0;
      else if (stop_det)
         frame_open_reg <= 1'b0;
      else if (start_det)
         frame_open_reg <= 1'b1;
   end

   // Link engine is held cleared outside frames, so a stopped clock costs nothing
   assign frame_rst_n = reset_n_in & frame_open_reg;

   // Snapshots only move while no frame is open; the link side reads them as static
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         snap_reg <= '0;
         lock_snap_reg <= 1'b1;
         asel_snap_reg <= 2'h0;
      end
      else if (!frame_open_reg)
      begin
         snap_reg <= rd_w;
         lock_snap_reg <= lock_s;
         asel_snap_reg <= asel_s;
      end
   end

   // Write toggle crosses in two flops, edge taken after them
   dsi_sync #(.W(1)) u_wr_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .d_in(wr_tog_reg),
      .q_out(wt_s)
   );

   // Last seen toggle value
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         wt_d_reg <= 1'b0;
      else
         wt_d_reg <= wt_s;
   end

   assign wr_pulse = wt_s ^ wt_d_reg;

   // Two sections behind one interface
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_sec
         dsi_sec_if sec_bus ();
         dsi_pkg::dsi_level_t lvl;
         // Only the addressed section takes the byte
         assign sec_bus.wr_stb = wr_pulse & (wr_sec_reg == 1'(i)) & ~lock_s;
         assign sec_bus.wr_data = wr_data_reg;
         assign sec_bus.clr = lock_s;
         assign sec_bus.flags = {flag_s[8 + i], flag_s[6 + i], flag_s[4 + i], flag_s[2 + i], flag_s[i]};
         assign rd_w[i] = sec_bus.rd_byte;
         assign ctrl_w[i] = sec_bus.ctrl;
         assign level_out[i] = lvl;
         dsi_section u_sec (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .bus(sec_bus.sec),
            .gate_in(gate_s[i]),
            .power_on_out(power_on_out[i]),
            .tone_drv_out(tone_drv_out[i]),
            .tone_run_out(tone_run_out[i]),
            .level_out(lvl),
            .static_limit_out(static_limit_out[i]),
            .thresh_high_out(thresh_high_out[i])
         );
      end
   endgenerate

   // ---------------- Link engine ----------------
   // Byte as it stands once the eighth bit is sampled, MSB first
   assign byte_w = {shift_reg[6:0], sda_in};
   assign last_bit = (bit_cnt_reg == `DSI_LAST_BIT);
   assign ack_slot = (bit_cnt_reg == `DSI_ACK_SLOT);
   // Eight data bits then one acknowledge slot
   assign cnt_next = ack_slot ? 4'h0 : 4'(bit_cnt_reg + 4'h1);
   // Fixed bits, then section bit, then the pin-chosen bit
   assign addr_hit = (byte_w[7:3] == `DSI_ADDR_FIXED) && (byte_w[1] == asel_snap_reg[byte_w[2]]);

   // Next state and the drive planned for the coming low phase
   always_comb
   begin
      state_next = state_reg;
      drv_next = 1'b0;
      tx_next = tx_reg;
      wr_fire = 1'b0;
      case (state_reg)
         dsi_pkg::DSI_ADDR:
         begin
            if (last_bit)
            begin
               if (addr_hit && !lock_snap_reg)
               begin
                  drv_next = 1'b1;
                  tx_next = snap_reg[byte_w[2]];
                  state_next = (byte_w[0] == `DSI_RW_READ) ? dsi_pkg::DSI_RDATA : dsi_pkg::DSI_WDATA;
               end
               else
                  state_next = dsi_pkg::DSI_SKIP;
            end
         end
         dsi_pkg::DSI_WDATA:
         begin
            if (last_bit)
            begin
               drv_next = ~lock_snap_reg;
               wr_fire = 1'b1;
            end
         end
         dsi_pkg::DSI_RDATA:
         begin
            // Master ack in the slot asks for another byte
            if (ack_slot)
            begin
               if (sda_in)
                  state_next = dsi_pkg::DSI_SKIP;
               else
               begin
                  tx_next = snap_reg[sec_sel_reg];
                  drv_next = ~tx_next[7];
               end
            end
            // Walk the byte out; release on the last bit for the master ack
            else if (!last_bit)
            begin
               tx_next = {tx_reg[6:0], 1'b0};
               drv_next = ~tx_next[7];
            end
         end
         dsi_pkg::DSI_SKIP:
         begin
            drv_next = 1'b0;
         end
         default:
         begin
            state_next = dsi_pkg::DSI_SKIP;
         end
      endcase
   end

   // Sample side of the link, on rising link clock
   always_ff @(posedge scl_in or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         state_reg <= dsi_pkg::DSI_ADDR;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         drv_pend_reg <= 1'b0;
         sec_sel_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         bit_cnt_reg <= cnt_next;
         shift_reg <= ack_slot ? shift_reg : byte_w;
         tx_reg <= tx_next;
         drv_pend_reg <= drv_next;
         sec_sel_reg <= (state_reg == dsi_pkg::DSI_ADDR && last_bit) ? byte_w[2] : sec_sel_reg;
      end
   end

   // Drive side changes only on the falling edge, so data is steady while clock is high
   always_ff @(negedge scl_in or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
         sda_oe_reg <= 1'b0;
      else
         sda_oe_reg <= drv_pend_reg;
   end

   // Written byte parks here; the toggle tells the system side
   always_ff @(posedge scl_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wr_data_reg <= 8'h00;
         wr_sec_reg <= 1'b0;
         wr_tog_reg <= 1'b0;
      end
      else if (wr_fire)
      begin
         wr_data_reg <= byte_w;
         wr_sec_reg <= sec_sel_reg;
         wr_tog_reg <= ~wr_tog_reg;
      end
   end

   // Open-drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_reg;

   // ---------------- Checks ----------------
   // Two clock domains meet here, so every check names its own clock and reset
   a_frame_on_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      start_det && !stop_det |=> frame_open_reg)
      else $error("frame did not open on start");
   a_frame_off_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      stop_det |=> !frame_open_reg)
      else $error("frame did not close on stop");
   a_write_stored: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wr_pulse && !lock_s |=> ctrl_w[$past(wr_sec_reg)] == $past(wr_data_reg))
      else $error("written byte not stored in addressed section");
   a_lock_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      lock_s |=> ctrl_w[0] == `DSI_SEC_RESET && ctrl_w[1] == `DSI_SEC_RESET)
      else $error("section not cleared under lockout");

   sequence s_addr_acked;
      state_reg == dsi_pkg::DSI_ADDR && last_bit && addr_hit && !lock_snap_reg;
   endsequence
   a_ack_addr: assert property (@(posedge scl_in) disable iff (!frame_rst_n)
      s_addr_acked |=> sda_oe_reg && ack_slot)
      else $error("matched address not acknowledged");
   sequence s_data_acked;
      state_reg == dsi_pkg::DSI_WDATA && last_bit && !lock_snap_reg;
   endsequence
   a_ack_data: assert property (@(posedge scl_in) disable iff (!frame_rst_n)
      s_data_acked |=> sda_oe_reg && ack_slot)
      else $error("written data byte not acknowledged");
   a_lock_no_ack: assert property (@(posedge scl_in) disable iff (!frame_rst_n)
      ack_slot && lock_snap_reg |-> !sda_oe_reg)
      else $error("acknowledge driven under lockout");
   a_skip_released: assert property (@(posedge scl_in) disable iff (!frame_rst_n)
      state_reg == dsi_pkg::DSI_SKIP |-> !sda_oe_reg)
      else $error("data line driven in ignored frame");
   sequence s_master_nack;
      state_reg == dsi_pkg::DSI_RDATA && ack_slot && sda_in;
   endsequence
   a_nack_ends: assert property (@(posedge scl_in) disable iff (!frame_rst_n)
      s_master_nack |=> state_reg == dsi_pkg::DSI_SKIP ##1 !sda_oe_reg)
      else $error("read not ended by master nack");
endmodule
`default_nettype wire

/* File: hdl/dsi_map.svh */
`ifndef DSI_MAP_SVH
`define DSI_MAP_SVH
// Fixed upper five bits of either section address
`define DSI_ADDR_FIXED 5'h02
// Read/write bit value that asks for a read
`define DSI_RW_READ 1'b1
// Write layout of the section byte, bit positions
`define DSI_W_LIMIT 7
`define DSI_W_TONE_EN 6
`define DSI_W_TONE_FORCE 5
`define DSI_W_COMP 4
`define DSI_W_HIGHV 3
`define DSI_W_ENABLE 2
`define DSI_W_THRESH 1
`define DSI_W_AUX 0
// Control bits copied into the read byte
`define DSI_R_CTRL_HI 4
`define DSI_R_CTRL_LO 2
// Reset value of a section register
`define DSI_SEC_RESET 8'h00
// Bit counter values: last data bit and acknowledge slot
`define DSI_LAST_BIT 4'h7
`define DSI_ACK_SLOT 4'h8
`endif

/* File: hdl/dsi_pkg.sv */
package dsi_pkg;
   // Link engine states, binary coded in the order address, write data, read data, skip
   typedef enum logic [1:0] {
      DSI_ADDR = 2'h0,
      DSI_WDATA = 2'h1,
      DSI_RDATA = 2'h2,
      DSI_SKIP = 2'h3
   } dsi_state_t;
   // Output level selected for a section
   typedef enum logic [2:0] {
      DSI_LVL_OFF = 3'h0,
      DSI_LVL_13V4 = 3'h1,
      DSI_LVL_18V5 = 3'h2,
      DSI_LVL_14V4 = 3'h3,
      DSI_LVL_19V5 = 3'h4,
      DSI_LVL_22V = 3'h5
   } dsi_level_t;
endpackage

/* File: hdl/dsi_sec_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Carrier between the serial front end and one section register
interface dsi_sec_if;
   logic wr_stb;
   logic [7:0] wr_data;
   logic clr;
   logic [4:0] flags;
   logic [7:0] ctrl;
   logic [7:0] rd_byte;
   modport ctl (output wr_stb, output wr_data, output clr, output flags, input ctrl, input rd_byte);
   modport sec (input wr_stb, input wr_data, input clr, input flags, output ctrl, output rd_byte);
endinterface
`default_nettype wire

/* File: hdl/dsi_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a bundle of unrelated levels
module dsi_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   // First stage, read only by the second
   logic [W-1:0] meta_reg;
   // Second stage, safe to use
   logic [W-1:0] sync_reg;

   // Both stages clear to zero on reset
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;
endmodule
`default_nettype wire

/* File: hdl/dsi_section.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsi_map.svh"
// One output section: control byte and its decoded controls
module dsi_section (
   input wire logic clk_in,
   input wire logic reset_n_in,
   dsi_sec_if.sec bus,
   input wire logic gate_in,
   output logic power_on_out,
   output logic tone_drv_out,
   output logic tone_run_out,
   output dsi_pkg::dsi_level_t level_out,
   output logic static_limit_out,
   output logic thresh_high_out
);
   // Stored control byte
   logic [7:0] ctrl_reg;
   // Named fields of the control byte
   wire enable = ctrl_reg[`DSI_W_ENABLE];
   wire tone_out_enable = ctrl_reg[`DSI_W_TONE_EN];
   wire tone_force_on = ctrl_reg[`DSI_W_TONE_FORCE];
   wire line_comp_raise = ctrl_reg[`DSI_W_COMP];
   wire high_voltage_sel = ctrl_reg[`DSI_W_HIGHV];
   wire aux_high_sel = ctrl_reg[`DSI_W_AUX];
   // Base level from the two level bits
   dsi_pkg::dsi_level_t base_level;

   // Lockout clear beats a write so nothing lands while supply is low
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ctrl_reg <= `DSI_SEC_RESET;
      else if (bus.clr)
         ctrl_reg <= `DSI_SEC_RESET;
      else if (bus.wr_stb)
         ctrl_reg <= bus.wr_data;
   end

   // Four levels from compensation and high select
   assign base_level = line_comp_raise ?
      (high_voltage_sel ? dsi_pkg::DSI_LVL_19V5 : dsi_pkg::DSI_LVL_14V4) :
      (high_voltage_sel ? dsi_pkg::DSI_LVL_18V5 : dsi_pkg::DSI_LVL_13V4);
   // Auxiliary select overrides; disabled section stays off
   assign level_out = !enable ? dsi_pkg::DSI_LVL_OFF :
      (aux_high_sel ? dsi_pkg::DSI_LVL_22V : base_level);
   // Main output follows enable only
   assign power_on_out = enable;
   // Tone driver is on with enable and tone output enable
   assign tone_drv_out = enable & tone_out_enable;
   // With the tone driver on, tone runs always when forced, else follows the gate pin
   assign tone_run_out = enable & tone_out_enable & (tone_force_on | gate_in);
   // Zero picks pulsed limiting, one static
   assign static_limit_out = enable & ctrl_reg[`DSI_W_LIMIT];
   // Zero picks the low threshold, one the high
   assign thresh_high_out = enable & ctrl_reg[`DSI_W_THRESH];
   // Write map held as is for the front end
   assign bus.ctrl = ctrl_reg;
   // Read byte: three flags, three copied controls, two flags
   assign bus.rd_byte = {bus.flags[4:2], ctrl_reg[`DSI_R_CTRL_HI:`DSI_R_CTRL_LO], bus.flags[1:0]};
endmodule
`default_nettype wire

/* File: sim/dsi_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Bus master on the two-wire link: clock stands high between frames
module dsi_master_model (
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   // Half of the 125 ns link clock period
   localparam realtime HALF = 62.5;
   // Idle bus: both lines released to the pull-up
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // Start: data falls while clock is high; lead time covers the device's clock sync
   task automatic start_frame();
      sda_low_out = 1'b1;
      #160;
      scl_out = 1'b0;
   endtask
   // Stop: data rises while clock is high, then a gap so the next start follows a stop
   task automatic stop_frame();
      #(HALF / 2) sda_low_out = 1'b1;
      #(HALF / 2) scl_out = 1'b1;
      #HALF sda_low_out = 1'b0;
      #200;
   endtask
   // One bit slot; data moves only in the low half, sampled just after rise and before fall
   task automatic bit_slot(input logic drive, output logic s_rise, output logic s_fall);
      #(HALF / 2) sda_low_out = ~drive;
      #(HALF / 2) scl_out = 1'b1;
      #1 s_rise = sda_in;
      #(HALF - 2) s_fall = sda_in;
      #1 scl_out = 1'b0;
   endtask
   // Send a byte MSB first, release data in the ack slot, report a steady low as ack
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic r;
      logic f;
      for (int i = 7; i >= 0; i--)
         bit_slot(b[i], r, f);
      bit_slot(1'b1, r, f);
      ack = ~r & ~f;
   endtask
   // Receive a byte MSB first, then ack to ask for more or nack to end the read
   task automatic read_byte(input logic more, output logic [7:0] b);
      logic r;
      logic f;
      for (int i = 7; i >= 0; i--)
      begin
         bit_slot(1'b1, r, f);
         b[i] = r;
      end
      bit_slot(~more, r, f);
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic clk_in = 1'b0; // System clock
   logic reset_n_in = 1'b0; // Active low reset
   logic lockout = 1'b0; // Supply-low indication
   logic [1:0] addr_sel = 2'b10; // Pin of A low, pin of B high
   logic [1:0] gate = 2'b00; // Tone gate per section
   logic [1:0] f_min = 2'b00; // Diagnostic flags, bit i for section i
   logic [1:0] f_volt = 2'b00;
   logic [1:0] f_tone = 2'b00;
   logic [1:0] f_ot = 2'b00;
   logic [1:0] f_ol = 2'b00;
   wire logic scl; // Link clock from the master
   wire logic m_low; // Master pulls data low
   wire logic sda_drv; // Device data level when enabled
   wire logic sda_oe; // Device pulls data low
   wire logic [1:0] pwr;
   wire logic [1:0] tdrv;
   wire logic [1:0] trun;
   wire logic [1:0] stat;
   wire logic [1:0] thr;
   wire logic [1:0][2:0] lvl;
   // Open-drain wire: pull-up wins unless someone pulls low
   wire logic sda_w = (sda_oe ? sda_drv : 1'b1) & ~m_low;
   int n_fail = 0;
   int checked = 0;
   // Control bytes covering every enabled level plus limit, tone enable and threshold
   logic [7:0] lvl_bytes [6] = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h1d, 8'hc6};
   // 50 MHz clock
   always #10 clk_in = ~clk_in;
   dsi_master_model dsi_master_model_inst (
      .scl_out(scl),
      .sda_low_out(m_low),
      .sda_in(sda_w)
   );
   dsi_i2c_target dsi_i2c_target_inst (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .scl_in(scl),
      .sda_in(sda_w),
      .sda_out(sda_drv),
      .sda_oe_out(sda_oe),
      .supply_low_lockout_in(lockout),
      .addr_sel_in(addr_sel),
      .tone_gate_input_in(gate),
      .min_current_flag_in(f_min),
      .voltage_fault_flag_in(f_volt),
      .tone_fault_flag_in(f_tone),
      .over_temp_flag_in(f_ot),
      .overload_flag_in(f_ol),
      .power_on_out(pwr),
      .tone_drv_out(tdrv),
      .tone_run_out(trun),
      .level_out(lvl),
      .static_limit_out(stat),
      .thresh_high_out(thr)
   );
   // Level selected by a control byte
   function automatic logic [2:0] exp_lvl(input logic [7:0] b);
      if (!b[2]) return dsi_pkg::DSI_LVL_OFF;
      if (b[0]) return dsi_pkg::DSI_LVL_22V;
      case (b[4:3])
         2'h0: return dsi_pkg::DSI_LVL_13V4;
         2'h1: return dsi_pkg::DSI_LVL_18V5;
         2'h2: return dsi_pkg::DSI_LVL_14V4;
         default: return dsi_pkg::DSI_LVL_19V5;
      endcase
   endfunction
   // Compare every decoded output of one section with what its byte implies
   task automatic chk_sec(input int s, input logic [7:0] b);
      `CHK("power_on", b[2], pwr[s])
      `CHK("tone_drv", b[2] & b[6], tdrv[s])
      `CHK("tone_run", b[2] & b[6] & (b[5] | gate[s]), trun[s])
      `CHK("level", exp_lvl(b), lvl[s])
      `CHK("static_limit", b[2] & b[7], stat[s])
      `CHK("thresh_high", b[2] & b[1], thr[s])
   endtask
   // Write frame; with abort set a refused address ends the frame at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ea, input logic ed, input logic abort);
      logic ack;
      dsi_master_model_inst.start_frame();
      dsi_master_model_inst.write_byte(a, ack);
      `CHK("addr_ack", ea, ack)
      if (ack | !abort)
      begin
         dsi_master_model_inst.write_byte(d, ack);
         `CHK("data_ack", ed, ack)
      end
      dsi_master_model_inst.stop_frame();
      repeat (4) @(posedge clk_in);
   endtask
   // Read frame of n bytes, all expected equal
   task automatic rd(input logic [7:0] a, input int n, input logic [7:0] e);
      logic ack;
      logic [7:0] b;
      dsi_master_model_inst.start_frame();
      dsi_master_model_inst.write_byte(a, ack);
      `CHK("raddr_ack", 1'b1, ack)
      for (int k = 0; k < n; k++)
      begin
         dsi_master_model_inst.read_byte(k < n - 1, b);
         `CHK("read_byte", e, b)
      end
      dsi_master_model_inst.stop_frame();
      repeat (4) @(posedge clk_in);
   endtask
   // Counts, verdict and end of run
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk_sec(0, 8'h00);
      chk_sec(1, 8'h00);
      rd(8'h11, 1, 8'h00);
      // Every level, section B must stay untouched
      foreach (lvl_bytes[i])
      begin
         wr(8'h10, lvl_bytes[i], 1'b1, 1'b1, 1'b1);
         chk_sec(0, lvl_bytes[i]);
         chk_sec(1, 8'h00);
      end
      wr(8'h16, 8'he5, 1'b1, 1'b1, 1'b1);
      chk_sec(1, 8'he5);
      chk_sec(0, 8'hc6);
      // Gate pin runs the tone while force is clear
      @(posedge clk_in);
      gate <= 2'b01;
      repeat (5) @(posedge clk_in);
      chk_sec(0, 8'hc6);
      // Pin bit mismatching either section: no ack, nothing stored
      wr(8'h12, 8'hff, 1'b0, 1'b0, 1'b1);
      wr(8'h14, 8'hff, 1'b0, 1'b0, 1'b1);
      chk_sec(0, 8'hc6);
      chk_sec(1, 8'he5);
      // Enable clear overrides every other control
      wr(8'h10, 8'hfb, 1'b1, 1'b1, 1'b1);
      chk_sec(0, 8'hfb);
      // Flags are snapshotted at frame start, so set them well before
      @(posedge clk_in);
      f_min <= 2'b01;
      f_volt <= 2'b10;
      f_tone <= 2'b01;
      f_ot <= 2'b10;
      f_ol <= 2'b01;
      repeat (5) @(posedge clk_in);
      rd(8'h11, 2, 8'hb9);
      rd(8'h17, 1, 8'h46);
      // Lockout clears registers and refuses a write, with both address and data acks checked absent
      @(posedge clk_in);
      lockout <= 1'b1;
      repeat (5) @(posedge clk_in);
      chk_sec(0, 8'h00);
      chk_sec(1, 8'h00);
      wr(8'h10, 8'h04, 1'b0, 1'b0, 1'b0);
      chk_sec(0, 8'h00);
      @(posedge clk_in);
      lockout <= 1'b0;
      repeat (5) @(posedge clk_in);
      wr(8'h10, 8'h04, 1'b1, 1'b1, 1'b1);
      chk_sec(0, 8'h04);
      // Swapped select pins: each section answers on its other address only
      @(posedge clk_in);
      addr_sel <= 2'b01;
      repeat (5) @(posedge clk_in);
      wr(8'h10, 8'h0c, 1'b0, 1'b0, 1'b1);
      chk_sec(0, 8'h04);
      wr(8'h12, 8'h0c, 1'b1, 1'b1, 1'b1);
      chk_sec(0, 8'h0c);
      rd(8'h15, 1, 8'h42);
      summarize();
   end
   // Hang guard
   initial
   begin
      repeat (60000) @(posedge clk_in);
      n_fail++;
      $display("[FAIL] run_time expected done seen timeout");
      summarize();
   end
endmodule
`default_nettype wire
